// >>> src/hsl_pkg.sv
// Shared constants and types of the host serial link (UART and SPI command port).
package hsl_pkg;

  // Core clock rate; the top-level module may override it to shorten bit times.
  localparam int unsigned CLK_HZ = 40_000_000;

  // Selectable UART rates, indexed by the baud select code.
  localparam int unsigned BAUD_NUM = 18;
  localparam int unsigned BAUD_RATE [BAUD_NUM] = '{
    300, 600, 1200, 2400, 4800, 9600, 14400, 19200, 28800, 38400,
    57600, 115200, 128000, 230400, 256000, 460800, 921600, 3000000
  };
  localparam logic [4:0]  BAUD_IDX_RST = 5'h0A;
  localparam logic [4:0]  BAUD_IDX_MAX = 5'h11;
  localparam logic [17:0] BAUD_DIV_MIN = 18'h00002;

  // Character and byte layout.
  localparam logic [2:0]  LAST_BIT  = 3'h7;
  localparam logic [7:0]  SPI_FILL  = 8'h00;
  localparam logic        LINE_IDLE = 1'b1;

  // Flow control is never applied, so the request line always reads ready.
  localparam logic        RTS_READY_N = 1'b0;

  typedef enum logic {
    LINK_UART,
    LINK_SPI
  } hsl_link_t;

  // One payload byte of the command message layer and the link it uses.
  typedef struct packed {
    logic [7:0] data;
    hsl_link_t  link;
  } hsl_msg_t;

  // Clock cycles per bit for a rate index; floor division keeps error below one cycle, except where the minimum of 2 applies.
  function automatic logic [17:0] baud_div(input int unsigned clk_hz, input logic [4:0] idx);
    int unsigned q;
    q = clk_hz / BAUD_RATE[idx];
    if (q < 2) begin
      q = 2;
    end
    return q[17:0];
  endfunction : baud_div

endpackage : hsl_pkg

// >>> src/hsl_uart_tx.sv
// UART transmitter: 8 data bits, no parity, one stop bit, LSB first.
`timescale 1ns/1ps
module hsl_uart_tx
  import hsl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Bit time
  input  wire logic [17:0] i_div,
  // Byte stream
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_data,
  output logic             o_ready,
  // Line
  output logic             o_txd
);

  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} hsl_tx_state_t;

  hsl_tx_state_t state_ff;
  logic [17:0]   cnt_ff;
  logic [2:0]    bit_ff;
  logic [7:0]    shift_ff;
  logic          txd_ff;
  logic          bit_end;

  assign bit_end = (cnt_ff == i_div - 18'h00001);
  assign o_ready = (state_ff == TX_IDLE);
  assign o_txd   = txd_ff;

  // The CTS input is deliberately not consulted: a byte is sent as soon as it is offered.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= TX_IDLE;
      cnt_ff   <= 18'h00000;
      bit_ff   <= 3'h0;
      shift_ff <= 8'h00;
      txd_ff   <= 1'b1;
    end else begin
      cnt_ff <= (state_ff == TX_IDLE || bit_end) ? 18'h00000 : cnt_ff + 18'h00001;
      unique case (state_ff)
        TX_IDLE: begin
          if (i_valid) begin
            shift_ff <= i_data;
            txd_ff   <= 1'b0;
            state_ff <= TX_START;
          end
        end
        TX_START: begin
          if (bit_end) begin
            txd_ff   <= shift_ff[0];
            bit_ff   <= 3'h0;
            state_ff <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            shift_ff <= {1'b0, shift_ff[7:1]};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == LAST_BIT) begin
              txd_ff   <= 1'b1;
              state_ff <= TX_STOP;
            end else begin
              txd_ff <= shift_ff[1];
            end
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            state_ff <= TX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : hsl_uart_tx

// >>> src/hsl_uart_rx.sv
// UART receiver: 8 data bits, no parity, one stop bit, LSB first, centre sampling.
`timescale 1ns/1ps
module hsl_uart_rx
  import hsl_pkg::*;
(
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Bit time
  input  wire logic [17:0] i_div,
  // Line
  input  wire logic        i_rxd,
  // Received bytes
  output logic             o_valid,
  output logic [7:0]       o_data,
  output logic             o_frame_err
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} hsl_rx_state_t;

  hsl_rx_state_t state_ff;
  logic          meta_ff;
  logic          rxd_ff;
  logic [17:0]   cnt_ff;
  logic [2:0]    bit_ff;
  logic [7:0]    shift_ff;
  logic          valid_ff;
  logic          err_ff;
  logic          half_hit;
  logic          full_hit;

  assign half_hit    = (cnt_ff == {1'b0, i_div[17:1]});
  assign full_hit    = (cnt_ff == i_div - 18'h00001);
  assign o_valid     = valid_ff;
  assign o_data      = shift_ff;
  assign o_frame_err = err_ff;

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      meta_ff <= LINE_IDLE;
      rxd_ff  <= LINE_IDLE;
    end else begin
      meta_ff <= i_rxd;
      rxd_ff  <= meta_ff;
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= RX_IDLE;
      cnt_ff   <= 18'h00000;
      bit_ff   <= 3'h0;
      shift_ff <= 8'h00;
      valid_ff <= 1'b0;
      err_ff   <= 1'b0;
    end else begin
      valid_ff <= 1'b0;
      err_ff   <= 1'b0;
      cnt_ff   <= cnt_ff + 18'h00001;
      unique case (state_ff)
        RX_IDLE: begin
          cnt_ff <= 18'h00000;
          if (!rxd_ff) begin
            state_ff <= RX_START;
          end
        end
        RX_START: begin
          if (half_hit) begin
            cnt_ff   <= 18'h00000;
            bit_ff   <= 3'h0;
            // A glitch shorter than half a bit is not a start bit.
            state_ff <= rxd_ff ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (full_hit) begin
            cnt_ff   <= 18'h00000;
            shift_ff <= {rxd_ff, shift_ff[7:1]};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == LAST_BIT) begin
              state_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (full_hit) begin
            valid_ff <= rxd_ff;
            err_ff   <= !rxd_ff;
            state_ff <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule : hsl_uart_rx

// >>> src/hsl_port.sv
// Host serial command port: UART and SPI mode 1 slave carrying one message layer.
`timescale 1ns/1ps
module hsl_port
  import hsl_pkg::*;
#(
  parameter int unsigned P_CLK_HZ = CLK_HZ
) (
  // Clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_reset,
  // UART pins
  input  wire logic       i_rxd,
  output logic            o_txd,
  output logic            o_rts_n,
  // SPI pins
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_pico,
  output logic            o_poci,
  output logic            o_poci_oe,
  // Rate control from the message layer
  input  wire logic       i_init_done,
  input  wire logic       i_baud_wr,
  input  wire logic [4:0] i_baud_sel,
  // Received bytes towards the message layer
  output logic            o_msg_valid,
  output hsl_msg_t        o_msg,
  output logic            o_frame_err,
  // Bytes from the message layer
  input  wire logic       i_tx_valid,
  input  wire hsl_msg_t   i_tx,
  output logic            o_tx_ready
);

  logic [4:0]  baud_idx_ff;
  logic [17:0] baud_div_ff;
  logic        u_rx_valid;
  logic [7:0]  u_rx_data;
  logic        u_tx_ready;
  logic        u_tx_go;
  logic        u_pend_ff;
  logic [7:0]  u_byte_ff;
  logic        s_pend_ff;
  logic        msg_valid_ff;
  hsl_msg_t    msg_ff;

  // SCLK domain.
  logic [2:0]  s_rx_cnt_ff;
  logic [7:0]  s_rx_shift_ff;
  logic [7:0]  s_rx_byte_ff;
  logic        s_rx_tgl_ff;
  logic [2:0]  s_tx_cnt_ff;
  logic [7:0]  s_tx_shift_ff;
  logic        s_grab_tgl_ff;

  // Core-domain side of the crossings.
  logic        rx_tgl_meta_ff;
  logic        rx_tgl_sync_ff;
  logic        rx_tgl_seen_ff;
  logic        grab_meta_ff;
  logic        grab_sync_ff;
  logic        grab_seen_ff;
  logic [7:0]  s_hold_ff;
  logic        s_hold_full_ff;
  logic        s_rx_event;
  logic        s_grab_event;
  logic        s_tx_go;

  // Rate select.

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      baud_idx_ff <= BAUD_IDX_RST;
    end else if (i_baud_wr && i_init_done && i_baud_sel <= BAUD_IDX_MAX) begin
      baud_idx_ff <= i_baud_sel;
    end
  end

  // Registered so the divide is off the bit counters' critical path.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      baud_div_ff <= BAUD_DIV_MIN;
    end else begin
      baud_div_ff <= baud_div(P_CLK_HZ, baud_idx_ff);
    end
  end

  // UART receiver and transmitter.

  hsl_uart_rx u_rx (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_div       (baud_div_ff),
    .i_rxd       (i_rxd),
    .o_valid     (u_rx_valid),
    .o_data      (u_rx_data),
    .o_frame_err (o_frame_err)
  );

  assign u_tx_go = i_tx_valid && i_tx.link == LINK_UART && u_tx_ready;

  hsl_uart_tx u_tx (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_div   (baud_div_ff),
    .i_valid (u_tx_go),
    .i_data  (i_tx.data),
    .o_ready (u_tx_ready),
    .o_txd   (o_txd)
  );

  assign o_rts_n = RTS_READY_N;

  // SPI logic in the SCLK domain.

  // Falling edges sample PICO, MSB first; chip select high clears the bit count.
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      s_rx_cnt_ff   <= 3'h0;
      s_rx_shift_ff <= 8'h00;
    end else begin
      s_rx_cnt_ff   <= s_rx_cnt_ff + 3'h1;
      s_rx_shift_ff <= {s_rx_shift_ff[6:0], i_pico};
    end
  end

  // The toggle survives chip select so a frame edge never looks like a byte.
  always_ff @(negedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      s_rx_byte_ff <= 8'h00;
      s_rx_tgl_ff  <= 1'b0;
    end else if (!i_cs_n && s_rx_cnt_ff == LAST_BIT) begin
      s_rx_byte_ff <= {s_rx_shift_ff[6:0], i_pico};
      s_rx_tgl_ff  <= !s_rx_tgl_ff;
    end
  end

  // Rising edges launch POCI; the hold byte is taken at the first bit of each byte.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      s_tx_cnt_ff   <= 3'h0;
      s_tx_shift_ff <= 8'h00;
    end else begin
      s_tx_cnt_ff <= s_tx_cnt_ff + 3'h1;
      if (s_tx_cnt_ff == 3'h0) begin
        s_tx_shift_ff <= s_hold_ff;
      end else begin
        s_tx_shift_ff <= {s_tx_shift_ff[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_sclk or posedge i_reset) begin
    if (i_reset) begin
      s_grab_tgl_ff <= 1'b0;
    end else if (!i_cs_n && s_tx_cnt_ff == 3'h0) begin
      s_grab_tgl_ff <= !s_grab_tgl_ff;
    end
  end

  assign o_poci    = s_tx_shift_ff[7];
  assign o_poci_oe = !i_cs_n;

  // SPI logic in the core domain.

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rx_tgl_meta_ff <= 1'b0;
      rx_tgl_sync_ff <= 1'b0;
      rx_tgl_seen_ff <= 1'b0;
      grab_meta_ff   <= 1'b0;
      grab_sync_ff   <= 1'b0;
      grab_seen_ff   <= 1'b0;
    end else begin
      rx_tgl_meta_ff <= s_rx_tgl_ff;
      rx_tgl_sync_ff <= rx_tgl_meta_ff;
      rx_tgl_seen_ff <= rx_tgl_sync_ff;
      grab_meta_ff   <= s_grab_tgl_ff;
      grab_sync_ff   <= grab_meta_ff;
      grab_seen_ff   <= grab_sync_ff;
    end
  end

  assign s_rx_event   = rx_tgl_sync_ff != rx_tgl_seen_ff;
  assign s_grab_event = grab_sync_ff != grab_seen_ff;
  assign s_tx_go      = i_tx_valid && i_tx.link == LINK_SPI && !s_hold_full_ff;

  // The hold byte must stay still near a byte boundary; the master's eight-clock byte
  // time leaves ample margin, but a message-layer byte offered just after a boundary, before the
  // grab event reaches the core, is overwritten by fill; offered in the grab event's own cycle, it is sent one byte later.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s_hold_ff      <= SPI_FILL;
      s_hold_full_ff <= 1'b0;
    end else if (s_tx_go) begin
      s_hold_ff      <= i_tx.data;
      s_hold_full_ff <= 1'b1;
    end else if (s_grab_event) begin
      s_hold_ff      <= SPI_FILL;
      s_hold_full_ff <= 1'b0;
    end
  end

  assign o_tx_ready = (i_tx.link == LINK_UART) ? u_tx_ready : !s_hold_full_ff;

  // Merge of both links into the message layer.

  // UART wins a tie; the other byte waits one cycle, and a new arrival beats the clear.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      u_pend_ff <= 1'b0;
      u_byte_ff <= 8'h00;
      s_pend_ff <= 1'b0;
    end else begin
      if (u_rx_valid) begin
        u_pend_ff <= 1'b1;
        u_byte_ff <= u_rx_data;
      end else if (u_pend_ff) begin
        u_pend_ff <= 1'b0;
      end
      if (s_rx_event) begin
        s_pend_ff <= 1'b1;
      end else if (s_pend_ff && !u_pend_ff) begin
        s_pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      msg_valid_ff <= 1'b0;
      msg_ff       <= '{data: 8'h00, link: LINK_UART};
    end else begin
      msg_valid_ff <= u_pend_ff || s_pend_ff;
      if (u_pend_ff) begin
        msg_ff <= '{data: u_byte_ff, link: LINK_UART};
      end else if (s_pend_ff) begin
        msg_ff <= '{data: s_rx_byte_ff, link: LINK_SPI};
      end
    end
  end

  assign o_msg_valid = msg_valid_ff;
  assign o_msg       = msg_ff;

  // Checks.

  property p_baud_after_reset;
    @(posedge i_mclk) !i_reset && $past(i_reset) |-> baud_idx_ff == BAUD_IDX_RST;
  endproperty
  a_baud_after_reset: assert property (p_baud_after_reset)
    else $error("rate index not at default after reset");

  property p_baud_guard;
    @(posedge i_mclk) disable iff (i_reset)
      baud_idx_ff != $past(baud_idx_ff) |-> $past(i_baud_wr) && $past(i_init_done);
  endproperty
  a_baud_guard: assert property (p_baud_guard)
    else $error("rate changed without an initialised write");

  property p_baud_range;
    @(posedge i_mclk) disable iff (i_reset) baud_idx_ff <= BAUD_IDX_MAX;
  endproperty
  a_baud_range: assert property (p_baud_range)
    else $error("rate index outside the supported set");

  property p_tx_start;
    @(posedge i_mclk) disable iff (i_reset) u_tx_go |=> !o_txd [*2];
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit not low");

  property p_tx_idle_high;
    @(posedge i_mclk) disable iff (i_reset) u_tx_ready |-> o_txd;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high)
    else $error("line not high while transmitter idle");

  property p_reset_quiet;
    @(posedge i_mclk) !i_reset && $past(i_reset) |-> o_txd && !o_msg_valid && o_tx_ready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("port not idle after reset");

  property p_uart_to_msg;
    @(posedge i_mclk) disable iff (i_reset)
      u_rx_valid |=> ##1 o_msg_valid && o_msg.link == LINK_UART &&
                         o_msg.data == $past(u_rx_data, 2);
  endproperty
  a_uart_to_msg: assert property (p_uart_to_msg)
    else $error("UART byte not passed to the message layer");

  property p_spi_to_msg;
    @(posedge i_mclk) disable iff (i_reset)
      s_rx_event && !u_pend_ff && !u_rx_valid |=> ##1 o_msg_valid && o_msg.link == LINK_SPI;
  endproperty
  a_spi_to_msg: assert property (p_spi_to_msg)
    else $error("SPI byte not passed to the message layer");

  property p_spi_msb_first;
    @(negedge i_sclk) disable iff (i_cs_n)
      s_rx_cnt_ff == LAST_BIT |=> s_rx_byte_ff[0] == $past(i_pico) &&
                                  s_rx_byte_ff[7] == $past(s_rx_shift_ff[6]);
  endproperty
  a_spi_msb_first: assert property (p_spi_msb_first)
    else $error("SPI receive byte not assembled MSB first");

  property p_spi_launch;
    @(posedge i_sclk) disable iff (i_cs_n) s_tx_cnt_ff == 3'h0 |=> o_poci == $past(s_hold_ff[7]);
  endproperty
  a_spi_launch: assert property (p_spi_launch)
    else $error("POCI not launched from hold MSB on rising edge");

  c_uart_byte:  cover property (@(posedge i_mclk) o_msg_valid && o_msg.link == LINK_UART);
  c_spi_byte:   cover property (@(posedge i_mclk) o_msg_valid && o_msg.link == LINK_SPI);
  c_baud_write: cover property (@(posedge i_mclk) i_baud_wr && i_init_done);
  c_spi_reply:  cover property (@(posedge i_mclk) s_grab_event && s_hold_full_ff);

endmodule : hsl_port

// >>> sim/hsl_host_model.sv
// Host-side partner of the serial port: UART terminal and SPI mode 1 master.
`timescale 1ns/1ps
module hsl_host_model (
  // UART lines
  output logic      o_rxd,
  input  wire logic i_txd,
  // SPI lines
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_pico,
  input  wire logic i_poci,
  input  wire logic i_poci_oe
);
  real        mon_bit_ns = 425.0;
  logic [8:0] rx_q [$];
  logic [8:0] rx_w;

  initial begin
    o_rxd  = 1'b1;
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_pico = 1'b0;
  end

  // A low stop bit is only sent when a framing error is wanted.
  task automatic uart_send(input logic [7:0] d, input logic stop, input real bit_ns);
    // Start off the core clock edge so the line never races the receiver's synchroniser.
    #3.1;
    o_rxd = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      o_rxd = d[i];
      #(bit_ns);
    end
    o_rxd = stop;
    #(bit_ns);
    o_rxd = 1'b1;
  endtask : uart_send

  // Centre sampling of the device line; it is never paced by flow control.
  always begin
    @(negedge i_txd);
    #(mon_bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      rx_w[i] = i_txd;
      #(mon_bit_ns);
    end
    rx_w[8] = i_txd;
    rx_q.push_back(rx_w);
  end

  // Two bytes per frame; the clock stands low outside frames.
  task automatic spi_xfer(input logic [15:0] tx, output logic [15:0] rx);
    #7.3;
    o_cs_n = 1'b0;
    #4000;
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_pico = tx[i];
      #62.5;
      rx[i] = i_poci_oe ? i_poci : 1'bx;
      o_sclk = 1'b0;
      #62.5;
    end
    #10;
    o_cs_n = 1'b1;
    o_pico = ~o_pico;
    #5000;
  endtask : spi_xfer
endmodule : hsl_host_model

// >>> sim/tb_top.sv
// Self-checking bench of the host serial port against the host partner model.
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top
  import hsl_pkg::*;
;
  // A slow nominal clock keeps the 300 baud character inside the run.
  localparam int unsigned CLK     = 1_000_000;
  localparam int          CYC_MAX = 90_000;
  logic       i_mclk, i_reset, i_init_done, i_baud_wr, i_tx_valid;
  logic [4:0] i_baud_sel;
  hsl_msg_t   i_tx, msg;
  wire logic  rxd, txd, rts_n, sclk, cs_n, pico, poci, poci_oe, msg_valid, frame_err, tx_ready;
  int         err_count = 0, check_count = 0, cyc = 0, fe_count = 0;
  hsl_msg_t   msg_q [$];

  hsl_port #(.P_CLK_HZ(CLK)) dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_rxd(rxd),
    .o_txd(txd), .o_rts_n(rts_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_pico(pico), .o_poci(poci),
    .o_poci_oe(poci_oe), .i_init_done(i_init_done), .i_baud_wr(i_baud_wr),
    .i_baud_sel(i_baud_sel), .o_msg_valid(msg_valid), .o_msg(msg), .o_frame_err(frame_err),
    .i_tx_valid(i_tx_valid), .i_tx(i_tx), .o_tx_ready(tx_ready));
  hsl_host_model host_u (.o_rxd(rxd), .i_txd(txd), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_pico(pico), .i_poci(poci), .i_poci_oe(poci_oe));

  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    if (msg_valid === 1'b1) msg_q.push_back(msg);
    if (frame_err === 1'b1) fe_count++;
    cyc++;
    if (cyc == CYC_MAX) begin
      err_count++;
      wrap_up();
    end
  end

  function automatic int exp_div(input int idx);
    int q;
    q = CLK / BAUD_RATE[idx];
    return (q < 2) ? 2 : q;
  endfunction : exp_div

  task automatic do_reset();
    i_reset <= 1'b1;
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_mclk);
  endtask : do_reset

  task automatic set_rate(input logic init, input logic [4:0] sel);
    @(posedge i_mclk);
    i_init_done <= init;
    i_baud_wr   <= 1'b1;
    i_baud_sel  <= sel;
    @(posedge i_mclk);
    i_baud_wr <= 1'b0;
    repeat (3) @(posedge i_mclk);
  endtask : set_rate

  // Holds the offer until the port is ready; returns right after the taking edge.
  task automatic offer(input logic [7:0] d, input hsl_link_t l);
    int n;
    @(posedge i_mclk);
    i_tx_valid <= 1'b1;
    i_tx       <= '{data: d, link: l};
    #1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 1000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    @(posedge i_mclk);
    i_tx_valid <= 1'b0;
  endtask : offer

  // Two characters back to back; the second may end with a low stop bit.
  task automatic uart_rx(input logic [7:0] d0, input logic [7:0] d1, input logic stop,
                         input int div);
    int       fe0;
    hsl_msg_t e0, e1, g;
    fe0 = fe_count;
    e0 = '{data: d0, link: LINK_UART};
    e1 = '{data: d1, link: LINK_UART};
    msg_q.delete();
    host_u.uart_send(d0, 1'b1, div * 25.0);
    host_u.uart_send(d1, stop, div * 25.0);
    repeat (div + 8) @(posedge i_mclk);
    `CHK(fe_count - fe0, stop ? 0 : 1)
    `CHK(msg_q.size(), stop ? 2 : 1)
    g = msg_q.size() > 0 ? msg_q.pop_front() : 'x;
    `CHK(g, e0)
    if (stop) begin
      g = msg_q.size() > 0 ? msg_q.pop_front() : 'x;
      `CHK(g, e1)
    end
  endtask : uart_rx

  task automatic t_reset_values();
    `CHK(txd, LINE_IDLE)
    `CHK(rts_n, RTS_READY_N)
    `CHK(tx_ready, 1'b1)
    `CHK(msg_valid, 1'b0)
    `CHK(poci_oe, 1'b0)
  endtask : t_reset_values

  task automatic t_refused();
    set_rate(1'b0, 5'h0B);
    uart_rx(8'hC6, 8'h39, 1'b1, exp_div(10));
    set_rate(1'b1, 5'h12);
    uart_rx(8'h0F, 8'hF0, 1'b1, exp_div(10));
  endtask : t_refused

  // Every rate index: character length and content on the transmit line.
  task automatic t_rates();
    int         d, n;
    logic [7:0] b;
    logic [8:0] g;
    for (int i = 0; i < BAUD_NUM; i++) begin
      d = exp_div(i);
      b = 8'h81 ^ 8'(i);
      set_rate(1'b1, 5'(i));
      host_u.mon_bit_ns = d * 25.0;
      host_u.rx_q.delete();
      offer(b, LINK_UART);
      #1;
      n = 0;
      while (tx_ready !== 1'b1 && n < 40000) begin
        @(posedge i_mclk);
        #1;
        n++;
      end
      `CHK(n, 10 * d)
      `CHK(rts_n, RTS_READY_N)
      g = host_u.rx_q.size() > 0 ? host_u.rx_q.pop_front() : 'x;
      `CHK(g, {1'b1, b})
    end
  endtask : t_rates

  task automatic t_reset_mid();
    set_rate(1'b1, 5'h0B);
    uart_rx(8'h96, 8'h69, 1'b1, exp_div(11));
    do_reset();
    `CHK(txd, LINE_IDLE)
    uart_rx(8'h3A, 8'hA3, 1'b1, exp_div(10));
  endtask : t_reset_mid

  // Loaded byte goes out first, then the empty hold sends fill.
  task automatic t_spi();
    logic [15:0] rx;
    hsl_msg_t    e0, e1, g;
    e0 = '{data: 8'h5A, link: LINK_SPI};
    e1 = '{data: 8'h81, link: LINK_SPI};
    msg_q.delete();
    offer(8'hC3, LINK_SPI);
    #1;
    `CHK(tx_ready, 1'b0)
    host_u.spi_xfer(16'h5A81, rx);
    `CHK(tx_ready, 1'b1)
    `CHK(rx, {8'hC3, SPI_FILL})
    `CHK(poci_oe, 1'b0)
    `CHK(msg_q.size(), 2)
    g = msg_q.size() > 0 ? msg_q.pop_front() : 'x;
    `CHK(g, e0)
    g = msg_q.size() > 0 ? msg_q.pop_front() : 'x;
    `CHK(g, e1)
  endtask : t_spi

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  initial begin
    i_reset     = 1'b1;
    i_init_done = 1'b0;
    i_baud_wr   = 1'b0;
    i_baud_sel  = 5'h00;
    i_tx_valid  = 1'b0;
    i_tx        = '0;
    do_reset();
    t_reset_values();
    uart_rx(8'hA5, 8'h5A, 1'b1, exp_div(10));
    uart_rx(8'h00, 8'hFF, 1'b0, exp_div(10));
    t_refused();
    t_rates();
    t_reset_mid();
    t_spi();
    wrap_up();
  end
endmodule : tb_top
